// File: tvd_dispatch.v
// Summary of operation
// - a trap finds its handler in an external vector area at the base register.
// - with the layout bit set the entry is a pointer at base plus vector times 4.
// - with the layout bit clear the handler starts at base plus vector times 256.
// - each source carries a vector number from 0 to 255 naming one entry.
// - vectors 0 to 63 are system and floating-point events only; a user event there is still dispatched and only sets rsvd_err.
// - the cache-off bit of the configuration disables the prediction cache.
// - both physical-mode bits set give untranslated fetch and data addresses.
// - with the disable-all bit set no interrupt or trap is taken.
// - the supervisor bit set runs the core in supervisor mode.
// - a timer holding zero raises no timer interrupt.
`timescale 1ns/1ps
`default_nettype none
`include "tvd_map.vh"
module tvd_dispatch (
  input  wire        clk_sys_in,
  input  wire        rst_n_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hsel_in,
  input  wire        hready_in,
  output reg  [31:0] hrdata_out,
  output wire        hreadyout_out,
  output wire        hresp_out,
  input  wire        event_req_in,
  input  wire [7:0]  event_vec_in,
  input  wire        event_user_in,
  output wire        event_ack_out,
  output reg         mem_rd_out,
  output reg  [31:0] mem_addr_out,
  input  wire        mem_ack_in,
  input  wire [31:0] mem_rdata_in,
  output reg         jump_out,
  output reg  [31:0] jump_addr_out,
  output wire        prediction_cache_off_out,
  output wire        instr_physical_mode_out,
  output wire        data_physical_mode_out,
  output wire        supervisor_out,
  output wire        timer_irq_out
);
  // ************************************************************
  // state
  // ************************************************************
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_READ = 3'b010;
  localparam [2:0] ST_JUMP = 3'b100;
  reg  [2:0]  state;
  reg  [1:0]  cfg;
  reg  [3:0]  cps;
  reg  [31:0] vab;
  reg  [7:0]  last_vec;
  reg         rsvd_err;
  reg  [31:0] entry_addr;
  reg         wr_pend;
  reg  [7:0]  wr_addr;
  reg         sw_req;
  reg  [7:0]  sw_vec;
  wire [31:0] calc_addr;
  wire [31:0] tmr_count;
  wire        tmr_irq;
  wire        bus_go;
  wire        take;
  wire [7:0]  take_vec;
  wire        take_user;
  wire        tmr_load;
  reg         pco_q;
  reg         ipm_q;
  reg         dpm_q;
  reg         sup_q;
  reg         tirq_q;
  // ************************************************************
  // ahb-lite slave, zero wait states
  // ************************************************************
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign bus_go = hsel_in & hready_in & htrans_in[1];
  assign tmr_load = wr_pend & (wr_addr == `TVD_OFF_TMR);
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wr_pend    <= 1'b0;
      wr_addr    <= 8'h00;
      hrdata_out <= 32'h0000_0000;
    end else begin
      wr_pend <= bus_go & hwrite_in;
      wr_addr <= haddr_in[7:0];
      if (bus_go & ~hwrite_in) begin
        case (haddr_in[7:0])
          `TVD_OFF_CFG:     hrdata_out <= {30'h0, cfg};
          `TVD_OFF_CPS:     hrdata_out <= {28'h0, cps};
          `TVD_OFF_VAB:     hrdata_out <= vab;
          `TVD_OFF_TMR:     hrdata_out <= tmr_count;
          `TVD_OFF_STAT:    hrdata_out <= {20'h0, rsvd_err, state,
                                           last_vec};
          `TVD_OFF_HANDLER: hrdata_out <= jump_addr_out;
          default:          hrdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cfg    <= `TVD_CFG_RST;
      cps    <= `TVD_CPS_RST;
      vab    <= `TVD_VAB_RST;
      sw_req <= 1'b0;
      sw_vec <= 8'h00;
      pco_q  <= 1'b0;
      ipm_q  <= 1'b0;
      dpm_q  <= 1'b0;
      sup_q  <= 1'b0;
    end else begin
      if (take)
        sw_req <= 1'b0;
      if (wr_pend) begin
        case (wr_addr)
          `TVD_OFF_CFG: begin
            cfg   <= hwdata_in[1:0];
            pco_q <= hwdata_in[`TVD_CFG_CD];
          end
          `TVD_OFF_CPS: begin
            cps   <= hwdata_in[3:0];
            // translation only bypassed when both bits are set
            ipm_q <= hwdata_in[`TVD_CPS_PI] &
                     hwdata_in[`TVD_CPS_PD];
            dpm_q <= hwdata_in[`TVD_CPS_PI] &
                     hwdata_in[`TVD_CPS_PD];
            sup_q <= hwdata_in[`TVD_CPS_SM];
          end
          `TVD_OFF_VAB: vab <= hwdata_in;
          `TVD_OFF_TRAP: begin
            sw_req <= 1'b1;
            sw_vec <= hwdata_in[7:0];
          end
          default: ;
        endcase
      end
    end
  end
  // ************************************************************
  // mode outputs
  // ************************************************************
  // own flops, loaded with the register write, so no gate sits on the pins
  assign prediction_cache_off_out = pco_q;
  assign instr_physical_mode_out  = ipm_q;
  assign data_physical_mode_out   = dpm_q;
  assign supervisor_out           = sup_q;
  // ************************************************************
  // timer
  // ************************************************************
  tvd_timer u_timer (
    .clk_sys_in  (clk_sys_in),
    .rst_n_in    (rst_n_in),
    .load_in     (tmr_load),
    .load_val_in (hwdata_in),
    .count_out   (tmr_count),
    .irq_out     (tmr_irq)
  );
  // registered pin, one cycle later than the count reaching zero
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      tirq_q <= 1'b0;
    end else begin
      tirq_q <= tmr_irq & ~cps[`TVD_CPS_DI];
    end
  end
  assign timer_irq_out = tirq_q;
  // ************************************************************
  // dispatch
  // ************************************************************
  // software traps win over the external source; external waits
  assign take_vec  = sw_req ? sw_vec : event_vec_in;
  assign take_user = sw_req ? 1'b0 : event_user_in;
  assign take = (sw_req | event_req_in) & (state == ST_IDLE) &
                ~cps[`TVD_CPS_DI];
  assign event_ack_out = take & ~sw_req;
  tvd_addr_calc u_calc (
    .base_in              (vab),
    .vec_in               (take_vec),
    .vector_layout_bit_in (cfg[`TVD_CFG_VF]),
    .addr_out             (calc_addr)
  );
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state         <= ST_IDLE;
      last_vec      <= 8'h00;
      rsvd_err      <= 1'b0;
      entry_addr    <= 32'h0000_0000;
      mem_rd_out    <= 1'b0;
      mem_addr_out  <= 32'h0000_0000;
      jump_out      <= 1'b0;
      jump_addr_out <= 32'h0000_0000;
    end else begin
      jump_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (take) begin
            last_vec   <= take_vec;
            entry_addr <= calc_addr;
            // user sources may not claim the reserved range; such a take is still dispatched and only sets rsvd_err
            rsvd_err   <= take_user &
                          (take_vec <= `TVD_VEC_RSVD_TOP);
            if (cfg[`TVD_CFG_VF]) begin
              mem_rd_out   <= 1'b1;
              mem_addr_out <= calc_addr;
              state        <= ST_READ;
            end else begin
              state <= ST_JUMP;
            end
          end
        end
        ST_READ: begin
          if (mem_ack_in) begin
            mem_rd_out    <= 1'b0;
            jump_out      <= 1'b1;
            jump_addr_out <= mem_rdata_in;
            state         <= ST_IDLE;
          end
        end
        ST_JUMP: begin
          jump_out      <= 1'b1;
          jump_addr_out <= entry_addr;
          state         <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: tvd_map.vh
`ifndef TVD_MAP_VH
`define TVD_MAP_VH
// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define TVD_OFF_CFG      8'h00
`define TVD_OFF_CPS      8'h04
`define TVD_OFF_VAB      8'h08
`define TVD_OFF_TMR      8'h0c
`define TVD_OFF_TRAP     8'h10
`define TVD_OFF_STAT     8'h14
`define TVD_OFF_HANDLER  8'h18
// ************************************************************
// field positions
// ************************************************************
`define TVD_CFG_VF       0
`define TVD_CFG_CD       1
`define TVD_CPS_PI       0
`define TVD_CPS_PD       1
`define TVD_CPS_SM       2
`define TVD_CPS_DI       3
// ************************************************************
// reset values and constants
// ************************************************************
`define TVD_CFG_RST      2'h0
`define TVD_CPS_RST      4'h0
`define TVD_VAB_RST      32'h0000_0000
`define TVD_TMR_RST      32'h0000_0000
`define TVD_VEC_RSVD_TOP 8'h3f
`define TVD_PTR_SHIFT    2
`define TVD_BLK_SHIFT    8
`endif

// File: tvd_addr_calc.v
`timescale 1ns/1ps
`default_nettype none
`include "tvd_map.vh"
module tvd_addr_calc (
  input  wire [31:0] base_in,
  input  wire [7:0]  vec_in,
  input  wire        vector_layout_bit_in,
  output wire [31:0] addr_out
);
  // ************************************************************
  // entry address
  // ************************************************************
  wire [31:0] vec_w;
  assign vec_w = {24'h000000, vec_in};
  assign addr_out = vector_layout_bit_in ?
    base_in + (vec_w << `TVD_PTR_SHIFT) :
    base_in + (vec_w << `TVD_BLK_SHIFT);
endmodule
`default_nettype wire

// File: tvd_timer.v
`timescale 1ns/1ps
`default_nettype none
module tvd_timer (
  input  wire        clk_sys_in,
  input  wire        rst_n_in,
  input  wire        load_in,
  input  wire [31:0] load_val_in,
  output reg  [31:0] count_out,
  output reg         irq_out
);
  // ************************************************************
  // down counter, zero means idle
  // ************************************************************
  always @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      count_out <= 32'h0000_0000;
      irq_out   <= 1'b0;
    end else if (load_in) begin
      count_out <= load_val_in;
      irq_out   <= 1'b0;
    end else if (count_out != 32'h0000_0000) begin
      count_out <= count_out - 32'h0000_0001;
      irq_out   <= (count_out == 32'h0000_0001);
    end else begin
      irq_out   <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: tvd_dispatch_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ******
// dispatch checks
// ******
module tvd_chk (
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        event_ack_out,
  input wire logic        mem_rd_out,
  input wire logic        mem_ack_in,
  input wire logic [31:0] mem_rdata_in,
  input wire logic        jump_out,
  input wire logic [31:0] jump_addr_out,
  input wire logic        instr_physical_mode_out,
  input wire logic        data_physical_mode_out,
  input wire logic        timer_irq_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  property p_take; event_ack_out |=> (mem_rd_out or (##1 jump_out)); endproperty
  a_take: assert property (p_take) else $error("dispatch late");
  property p_idle;
    event_ack_out |-> !mem_rd_out ##1 !event_ack_out;
  endproperty
  a_idle: assert property (p_idle) else $error("take while busy");
  property p_hold; mem_rd_out && !mem_ack_in |=> mem_rd_out; endproperty
  a_hold: assert property (p_hold) else $error("fetch dropped");
  property p_ptr;
    mem_rd_out && mem_ack_in |=>
      jump_out && jump_addr_out == $past(mem_rdata_in);
  endproperty
  a_ptr: assert property (p_ptr) else $error("bad pointer jump");
  property p_pulse; jump_out |=> !jump_out; endproperty
  a_pulse: assert property (p_pulse) else $error("jump too long");
  property p_keep; !jump_out |-> $stable(jump_addr_out); endproperty
  a_keep: assert property (p_keep) else $error("target moved");
  property p_timer; timer_irq_out |=> !timer_irq_out; endproperty
  a_timer: assert property (p_timer) else $error("irq at zero");
  property p_phys;
    instr_physical_mode_out == data_physical_mode_out;
  endproperty
  a_phys: assert property (p_phys) else $error("phys split");
endmodule
`default_nettype wire

// File: tvd_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ******
// vector area memory
// ******
module tvd_mem (
  input  wire logic        clk_sys_in,
  input  wire logic        slow_in,
  input  wire logic        mem_rd_in,
  input  wire logic [31:0] mem_addr_in,
  output var  logic        mem_ack_out,
  output var  logic [31:0] mem_rdata_out
);
  logic [1:0] wait_cnt = 2'h0;
  initial mem_ack_out = 1'b0;
  initial mem_rdata_out = 32'h0;
  // pointer is the inverse of its entry address, so no two entries match
  always @(posedge clk_sys_in) begin
    mem_ack_out <= 1'b0;
    mem_rdata_out <= ~mem_rdata_out;
    wait_cnt <= 2'h0;
    if (mem_rd_in && !mem_ack_out) begin
      wait_cnt <= wait_cnt + 2'h1;
      if (!slow_in || wait_cnt == 2'h3) begin
        mem_ack_out <= 1'b1;
        mem_rdata_out <= ~mem_addr_in;
      end
    end
  end
endmodule
`default_nettype wire

// File: test_trap_vector_dispatch.sv
`timescale 1ns/1ps
`default_nettype none
// ******
// dispatch bench
// ******
module test_trap_vector_dispatch;
  localparam logic [31:0] base = 32'h8000_0000;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic        req = 1'b0;
  logic [7:0]  vec = 8'h0;
  logic        user = 1'b0;
  logic        slow = 1'b0;
  logic [31:0] rd;
  logic [31:0] cps_v [4] = '{32'h1, 32'h2, 32'h3, 32'h4};
  logic [31:0] cps_e [4] = '{32'h8, 32'h8, 32'he, 32'h9};
  logic [7:0]  vecs [4] = '{8'h00, 8'h3f, 8'h40, 8'hff};
  wire  [31:0] hrdata, maddr, mdata, jaddr;
  wire         rdy, ack, mrd, mack, jump, pco, ipm, dpm, sup, tirq, resp;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles = 0;
  int          jumps = 0;
  int          tirqs = 0;
  int          n;
  always #4 clk_sys_in = ~clk_sys_in;
  tvd_dispatch u_dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(3'h2), .hwdata_in(hwdata), .hsel_in(1'b1),
    .hready_in(rdy), .hrdata_out(hrdata), .hreadyout_out(rdy),
    .hresp_out(resp), .event_req_in(req), .event_vec_in(vec),
    .event_user_in(user), .event_ack_out(ack), .mem_rd_out(mrd),
    .mem_addr_out(maddr), .mem_ack_in(mack), .mem_rdata_in(mdata),
    .jump_out(jump), .jump_addr_out(jaddr),
    .prediction_cache_off_out(pco), .instr_physical_mode_out(ipm),
    .data_physical_mode_out(dpm), .supervisor_out(sup),
    .timer_irq_out(tirq));
  tvd_mem u_mem (.clk_sys_in(clk_sys_in), .slow_in(slow),
    .mem_rd_in(mrd), .mem_addr_in(maddr), .mem_ack_out(mack),
    .mem_rdata_out(mdata));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %h, not %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk_sys_in);
    while (rdy !== 1'b1) @(posedge clk_sys_in);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys_in);
    while (rdy !== 1'b1) @(posedge clk_sys_in);
    rd = hrdata;
  endtask
  task automatic wjump(input logic [31:0] exp);
    for (int k = 0; k < 20 && jump !== 1'b1; k++) @(posedge clk_sys_in);
    chk({31'h0, jump}, 32'h1);
    chk(jaddr, exp);
  endtask
  task automatic ev(input logic [7:0] v, input logic u);
    req <= 1'b1;
    vec <= v;
    user <= u;
    @(posedge clk_sys_in);
    for (int k = 0; k < 20 && ack !== 1'b1; k++) @(posedge clk_sys_in);
    chk({31'h0, ack}, 32'h1);
    req <= 1'b0;
  endtask
  task automatic test_done();
    if (miscompares == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_sys_in) begin
    cycles++;
    jumps += (jump === 1'b1);
    tirqs += (tirq === 1'b1);
    if (cycles == 3000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    @(posedge clk_sys_in);
    bus(1'b0, 32'h40, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, resp}, 32'h0);
    bus(1'b1, 32'h0, 32'h2);
    foreach (cps_v[i]) begin
      bus(1'b1, 32'h4, cps_v[i]);
      @(posedge clk_sys_in);
      chk({28'h0, pco, ipm, dpm, sup}, cps_e[i]);
    end
    bus(1'b1, 32'h8, base);
    foreach (vecs[i]) begin
      bus(1'b1, 32'h10, {24'h0, vecs[i]});
      wjump(base + {16'h0, vecs[i], 8'h0});
    end
    ev(8'h05, 1'b1);
    wjump(base + 32'h500);
    bus(1'b0, 32'h14, 32'h0);
    chk(rd & 32'hfff, 32'h905);
    bus(1'b1, 32'h4, 32'h8);
    n = jumps;
    bus(1'b1, 32'h10, 32'h50);
    repeat (10) @(posedge clk_sys_in);
    chk(32'(jumps), 32'(n));
    bus(1'b1, 32'h4, 32'h0);
    wjump(base + 32'h5000);
    bus(1'b1, 32'h0, 32'h1);
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      bus(1'b1, 32'h10, 32'h80);
      wjump(~(base + 32'h200));
    end
    ev(8'hff, 1'b0);
    wjump(~(base + 32'h3fc));
    bus(1'b0, 32'h14, 32'h0);
    chk(rd & 32'hfff, 32'h1ff);
    bus(1'b0, 32'h18, 32'h0);
    chk(rd, ~(base + 32'h3fc));
    bus(1'b1, 32'hc, 32'h4);
    repeat (8) @(posedge clk_sys_in);
    chk(32'(tirqs), 32'h1);
    test_done();
  end
endmodule
bind tvd_dispatch tvd_chk u_chk (.clk_sys_in(clk_sys_in),
  .rst_n_in(rst_n_in), .event_ack_out(event_ack_out),
  .mem_rd_out(mem_rd_out), .mem_ack_in(mem_ack_in),
  .mem_rdata_in(mem_rdata_in), .jump_out(jump_out),
  .jump_addr_out(jump_addr_out),
  .instr_physical_mode_out(instr_physical_mode_out),
  .data_physical_mode_out(data_physical_mode_out),
  .timer_irq_out(timer_irq_out));
`default_nettype wire
